// [hw/efl_fault_log.sv]
// Purpose: fault and caution logging with preset pin handling
// Assumes: one clock, sensor and supply monitors give synchronous levels
// Notes:   logs reach software only over the register channel in rich mode
//
// Operation
// - preset pin low two to four seconds zeroes single and multi turn counts
// - preset pin low over thirty seconds clears all latched faults and cautions
// - preset makes the present shaft angle zero for later reports
// - preset pin high or floating is idle and does nothing
// - active-low fault and caution flags go out with every position report
// - fault log holds the cause whenever the fault flag is active
// - logs are readable only over the rich protocol register channel
// - fault log bits: signal, position, startup, memory, battery, magnet
// - caution log bits: supply, sensor not ready, hot, cold, battery early
// - hot caution when junction temperature exceeds upper limit, default 140
// - cold caution when junction temperature below lower limit, default -40
// - sensor not ready caution stands until the sensor settles
// - magnet fault when the disc is not detected
// - battery fault when backup voltage falls below the error threshold on low-power option units
// - battery early caution below warning threshold on low-power option units
// - supply caution when main supply leaves its range
// - clear command or power cycle clears fault and caution bits
// - backup loss with main power present latches the battery fault on low-power option units
// - battery early caution self-clears; battery fault stays latched
module efl_fault_log #(
    parameter int unsigned          ST_W       = 16,
    parameter int unsigned          MT_W       = 16,
    parameter efl_pkg::efl_cycles_t PRESET_MIN = efl_pkg::PRESET_MIN_CYC,
    parameter efl_pkg::efl_cycles_t PRESET_MAX = efl_pkg::PRESET_MAX_CYC,
    parameter efl_pkg::efl_cycles_t CLEAR_MIN  = efl_pkg::CLEAR_MIN_CYC
) (
    input  wire logic              core_clk,
    input  wire logic              sys_rst,
    input  wire logic              clkEn,
    // preset pin and clear command
    input  wire logic              presetPin,
    input  wire logic              clearFaultsCommand,
    // register channel
    input  wire logic              bissMode,
    input  wire logic              regReq,
    input  wire logic              regWrite,
    input  wire logic [7:0]        regBank,
    input  wire logic [7:0]        regAddr,
    input  wire logic [7:0]        regWData,
    output logic      [7:0]        regRData,
    output logic                   regAck,
    // raw position from the sensing chain
    input  wire logic [ST_W-1:0]   rawAngle,
    input  wire logic [MT_W-1:0]   rawTurns,
    // fault sources
    input  wire logic              signalFault,
    input  wire logic              positionFault,
    input  wire logic              startupFault,
    input  wire logic              memoryFault,
    input  wire logic              magnetDetected,
    // supply and backup monitors
    input  wire logic              mainSupplyInRange,
    input  wire logic              backupPresent,
    input  wire logic              backupBelowWarn,
    input  wire logic              backupBelowError,
    input  wire logic              lowPowerBackupOption,
    // temperature sensor
    input  wire logic              tempSensorReady,
    input  wire logic signed [15:0] junctionTemp,
    // position report fields
    output logic      [ST_W-1:0]   singleTurnCount,
    output logic      [MT_W-1:0]   multiTurnCount,
    output logic                   faultFlagLow,
    output logic                   cautionFlagLow
);

    typedef struct packed {
        logic            strapDone;
        logic            lowPowerOpt;
        logic [7:0]      faultLog;
        logic [7:0]      cautionLog;
        logic [7:0]      tempHi;
        logic [7:0]      tempLo;
        logic [ST_W-1:0] stOffset;
        logic [MT_W-1:0] mtOffset;
        logic [ST_W-1:0] stCount;
        logic [MT_W-1:0] mtCount;
        logic            faultFlagLow;
        logic            cautionFlagLow;
        logic [7:0]      regRData;
        logic            regAck;
    } efl_state_t;

    efl_state_t st;
    efl_state_t next_st;

    logic presetPulse;
    logic pinClearPulse;

    // idle-high pin never produces a pulse: timer only counts low cycles
    efl_hold_timer #(
        .PRESET_MIN (PRESET_MIN),
        .PRESET_MAX (PRESET_MAX),
        .CLEAR_MIN  (CLEAR_MIN)
    ) u_hold_timer (
        .core_clk    (core_clk),
        .sys_rst     (sys_rst),
        .clkEn       (clkEn),
        .presetPin   (presetPin),
        .presetPulse (presetPulse),
        .clearPulse  (pinClearPulse)
    );

    // combinational views of sources
    logic              clearAll;
    logic [7:0]        faultSet;
    logic [7:0]        cautionLatchSet;
    logic [7:0]        cautionLive;
    logic signed [15:0] hiLimit;
    logic signed [15:0] loLimit;
    logic              logBankHit;

    always_comb begin
        clearAll = clearFaultsCommand | pinClearPulse;

        // upper limit is unsigned degrees, lower limit signed degrees
        hiLimit = $signed({8'h00, st.tempHi});
        loLimit = $signed({{8{st.tempLo[7]}}, st.tempLo});

        faultSet                          = '0;
        faultSet[efl_pkg::FAULT_SIGNAL]   = signalFault;
        faultSet[efl_pkg::FAULT_POSITION] = positionFault;
        faultSet[efl_pkg::FAULT_STARTUP]  = startupFault;
        faultSet[efl_pkg::FAULT_MEMORY]   = memoryFault;
        faultSet[efl_pkg::FAULT_BATTERY]  = st.lowPowerOpt &
            (backupBelowError |
             (mainSupplyInRange & ~backupPresent));
        faultSet[efl_pkg::FAULT_MAGNET]   = ~magnetDetected;

        cautionLatchSet = '0;
        cautionLatchSet[efl_pkg::CAUTION_SUPPLY] = ~mainSupplyInRange;
        // comparisons are only trusted once the sensor has settled
        cautionLatchSet[efl_pkg::CAUTION_HOT]  =
            tempSensorReady & (junctionTemp > hiLimit);
        cautionLatchSet[efl_pkg::CAUTION_COLD] =
            tempSensorReady & (junctionTemp < loLimit);

        // live bits follow their source and need no clear
        cautionLive = '0;
        cautionLive[efl_pkg::CAUTION_NOTREADY] = ~tempSensorReady;
        cautionLive[efl_pkg::CAUTION_BATTERY]  =
            st.lowPowerOpt & backupBelowWarn;

        logBankHit = regBank == efl_pkg::LOG_BANK;
    end

    always_comb begin
        next_st        = st;
        next_st.regAck = 1'b0;

        // option strap is caught once, at the first enabled edge after reset
        if (!st.strapDone) begin
            next_st.strapDone   = 1'b1;
            next_st.lowPowerOpt = lowPowerBackupOption;
        end

        // a new cause in the clearing cycle survives the clear
        next_st.faultLog = (faultSet | (st.faultLog & ~{8{clearAll}}))
                           & efl_pkg::FAULT_USED;
        next_st.cautionLog = (((cautionLatchSet | (st.cautionLog & ~{8{clearAll}}))
                               & efl_pkg::CAUTION_LATCHED) | cautionLive)
                             & efl_pkg::CAUTION_USED;

        // flags derive from the very log value stored with them
        next_st.faultFlagLow   = ~|next_st.faultLog;
        next_st.cautionFlagLow = ~|next_st.cautionLog;

        if (presetPulse) begin
            next_st.stOffset = rawAngle;
            next_st.mtOffset = rawTurns;
        end
        // reports count from the preset point, wrapping naturally
        next_st.stCount = rawAngle - next_st.stOffset;
        next_st.mtCount = rawTurns - next_st.mtOffset;

        // plain serial mode has no register channel: requests are ignored
        if (regReq && bissMode) begin
            next_st.regAck   = 1'b1;
            next_st.regRData = efl_pkg::UNMAPPED_DATA;
            if (logBankHit) begin
                unique case (regAddr)
                    efl_pkg::FAULT_LOG_ADDR: begin
                        next_st.regRData = st.faultLog;
                    end
                    efl_pkg::CAUTION_LOG_ADDR: begin
                        next_st.regRData = st.cautionLog;
                    end
                    efl_pkg::TEMP_HI_ADDR: begin
                        next_st.regRData = st.tempHi;
                        // limits are frozen while the sensor is unsettled
                        if (regWrite && tempSensorReady) begin
                            next_st.tempHi = regWData;
                        end
                    end
                    efl_pkg::TEMP_LO_ADDR: begin
                        next_st.regRData = st.tempLo;
                        if (regWrite && tempSensorReady) begin
                            next_st.tempLo = regWData;
                        end
                    end
                    default: begin
                        next_st.regRData = efl_pkg::UNMAPPED_DATA;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            // power cycle leaves both logs empty
            st                <= '0;
            st.faultLog       <= efl_pkg::LOG_RST;
            st.cautionLog     <= efl_pkg::LOG_RST;
            st.tempHi         <= efl_pkg::TEMP_HI_RST;
            st.tempLo         <= efl_pkg::TEMP_LO_RST;
            st.faultFlagLow   <= 1'b1;
            st.cautionFlagLow <= 1'b1;
        end else if (clkEn) begin
            st <= next_st;
        end
    end

    // position report fields, flags travel with them
    assign singleTurnCount = st.stCount;
    assign multiTurnCount  = st.mtCount;
    assign faultFlagLow    = st.faultFlagLow;
    assign cautionFlagLow  = st.cautionFlagLow;
    assign regRData        = st.regRData;
    assign regAck          = st.regAck;

endmodule // efl_fault_log

// [hw/efl_hold_timer.sv]
// Purpose: times how long the preset pin is held low
// Assumes: pin is synchronous to core_clk, high or floating means idle
// Notes:   decides only on release, so a long hold never presets on its way
module efl_hold_timer #(
    parameter efl_pkg::efl_cycles_t PRESET_MIN = efl_pkg::PRESET_MIN_CYC,
    parameter efl_pkg::efl_cycles_t PRESET_MAX = efl_pkg::PRESET_MAX_CYC,
    parameter efl_pkg::efl_cycles_t CLEAR_MIN  = efl_pkg::CLEAR_MIN_CYC
) (
    input  wire logic core_clk,
    input  wire logic sys_rst,
    input  wire logic clkEn,
    input  wire logic presetPin,
    output logic      presetPulse,
    output logic      clearPulse
);

    typedef struct packed {
        efl_pkg::efl_cycles_t lowCount;
        logic                 held;
        logic                 presetPulse;
        logic                 clearPulse;
    } efl_timer_t;

    efl_timer_t st;
    efl_timer_t next_st;

    always_comb begin
        next_st             = st;
        next_st.presetPulse = 1'b0;
        next_st.clearPulse  = 1'b0;
        if (!presetPin) begin
            next_st.held = 1'b1;
            // saturate so a very long hold still reads as long
            if (st.lowCount != '1) begin
                next_st.lowCount = st.lowCount + 32'h1;
            end
        end else begin
            next_st.held     = 1'b0;
            next_st.lowCount = '0;
            if (st.held) begin
                next_st.presetPulse = (st.lowCount >= PRESET_MIN) &&
                                      (st.lowCount <= PRESET_MAX);
                next_st.clearPulse  = st.lowCount > CLEAR_MIN;
            end
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            st <= '0;
        end else if (clkEn) begin
            st <= next_st;
        end
    end

    assign presetPulse = st.presetPulse;
    assign clearPulse  = st.clearPulse;

endmodule // efl_hold_timer

// [include/efl_pkg.sv]
// Purpose: shared constants for the fault log and preset block
// Assumes: 100 MHz core clock, 8-bit register channel data
// Notes:   bank and addresses are those of the register channel
package efl_pkg;

    // register channel map
    localparam logic [7:0] LOG_BANK         = 8'h44;
    localparam logic [7:0] FAULT_LOG_ADDR   = 8'h10;
    localparam logic [7:0] CAUTION_LOG_ADDR = 8'h11;
    localparam logic [7:0] TEMP_HI_ADDR     = 8'h12;
    localparam logic [7:0] TEMP_LO_ADDR     = 8'h13;
    localparam logic [7:0] UNMAPPED_DATA    = 8'h00;

    // fault log bit positions
    localparam int unsigned FAULT_SIGNAL   = 0;
    localparam int unsigned FAULT_POSITION = 1;
    localparam int unsigned FAULT_STARTUP  = 2;
    localparam int unsigned FAULT_MEMORY   = 3;
    localparam int unsigned FAULT_BATTERY  = 4;
    localparam int unsigned FAULT_MAGNET   = 5;
    localparam logic [7:0]  FAULT_USED     = 8'h3f;

    // caution log bit positions
    localparam int unsigned CAUTION_SUPPLY   = 0;
    localparam int unsigned CAUTION_NOTREADY = 1;
    localparam int unsigned CAUTION_HOT      = 2;
    localparam int unsigned CAUTION_COLD     = 3;
    localparam int unsigned CAUTION_BATTERY  = 4;
    localparam logic [7:0]  CAUTION_LATCHED  = 8'h0d;
    localparam logic [7:0]  CAUTION_USED     = 8'h1f;

    // reset values
    localparam logic [7:0] LOG_RST     = 8'h00;
    localparam logic [7:0] TEMP_HI_RST = 8'h8c;
    localparam logic [7:0] TEMP_LO_RST = 8'hd8;

    // preset pin hold times
    localparam longint unsigned CLK_HZ        = 64'd100_000_000;
    localparam longint unsigned MS_PER_S      = 64'd1000;
    localparam longint unsigned PRESET_MIN_MS = 64'd2000;
    localparam longint unsigned PRESET_MAX_MS = 64'd4000;
    localparam longint unsigned CLEAR_MIN_MS  = 64'd30000;

    typedef logic [31:0] efl_cycles_t;

    // preset least time rounds up, preset longest and clear least time round down
    localparam efl_cycles_t PRESET_MIN_CYC =
        efl_cycles_t'((PRESET_MIN_MS * CLK_HZ + MS_PER_S - 64'd1) / MS_PER_S);
    localparam efl_cycles_t PRESET_MAX_CYC =
        efl_cycles_t'((PRESET_MAX_MS * CLK_HZ) / MS_PER_S);
    localparam efl_cycles_t CLEAR_MIN_CYC =
        efl_cycles_t'((CLEAR_MIN_MS * CLK_HZ) / MS_PER_S);

endpackage

// [testbench/efl_checker.sv]
// Purpose: port-level assertions for the fault log block
// Assumes: upper temperature limit is never raised above its reset value
// Notes:   log contents are seen only through flags and the register channel
module efl_checker (
    input wire logic              core_clk,
    input wire logic              sys_rst,
    input wire logic              clkEn,
    input wire logic              bissMode,
    input wire logic              regReq,
    input wire logic [7:0]        regBank,
    input wire logic [7:0]        regRData,
    input wire logic              regAck,
    input wire logic              signalFault,
    input wire logic              magnetDetected,
    input wire logic              mainSupplyInRange,
    input wire logic              tempSensorReady,
    input wire logic signed [15:0] junctionTemp,
    input wire logic              faultFlagLow,
    input wire logic              cautionFlagLow
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    property p_ack; clkEn && regReq && bissMode |=> regAck; endproperty
    property p_no_ack; clkEn && !(regReq && bissMode) |=> !regAck; endproperty
    property p_unmapped;
        clkEn && regReq && bissMode && regBank != 8'h44 |=> regRData == 8'h00;
    endproperty
    property p_signal; clkEn && signalFault |=> !faultFlagLow; endproperty
    property p_magnet; clkEn && !magnetDetected |=> !faultFlagLow; endproperty
    property p_supply; clkEn && $fell(mainSupplyInRange) |=> !cautionFlagLow; endproperty
    property p_notready; clkEn && !tempSensorReady |=> !cautionFlagLow; endproperty
    property p_hot;
        clkEn && tempSensorReady && junctionTemp > 16'sd140 |=> !cautionFlagLow;
    endproperty
    a_ack: assert property (p_ack)
        else $error("register request not acknowledged");
    a_no_ack: assert property (p_no_ack)
        else $error("acknowledge without accepted request");
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped read returned nonzero data");
    a_signal: assert property (p_signal)
        else $error("signal fault did not drive fault flag");
    a_magnet: assert property (p_magnet)
        else $error("missing disc did not drive fault flag");
    a_supply: assert property (p_supply)
        else $error("supply low did not drive caution flag");
    a_notready: assert property (p_notready)
        else $error("sensor not ready did not drive caution flag");
    a_hot: assert property (p_hot)
        else $error("over temperature did not drive caution flag");
    c_ack: cover property (regAck);
    c_fault: cover property ($fell(faultFlagLow));
    c_caution: cover property ($fell(cautionFlagLow));
endmodule // efl_checker

// [testbench/efl_preset_driver.sv]
// Purpose: controller model driving the preset pin
// Assumes: pin idles high, as if tied up or floating
// Notes:   changes the pin on falling edges so each low cycle is one sample
module efl_preset_driver (
    input wire logic core_clk,
    output logic     presetPin
);
    timeunit 1ns;
    timeprecision 1ps;
    initial presetPin = 1'b1;
    task automatic hold(input int n);
        presetPin = 1'b0;
        repeat (n) @(negedge core_clk);
        presetPin = 1'b1;
    endtask
endmodule // efl_preset_driver

// [testbench/tb_top.sv]
// Purpose: self-checking bench for the fault log and preset block
// Assumes: short hold parameters 20/40/300 cycles
// Notes:   clkEn is driven, a short freeze and a second reset are exercised
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk, sys_rst, clearFaultsCommand, bissMode, regReq, regWrite, regAck, clkEn;
    logic [7:0] regBank, regAddr, regWData, regRData;
    logic [15:0] rawAngle, rawTurns, singleTurnCount, multiTurnCount;
    logic [4:0] flt;
    logic mainSupplyInRange, backupPresent, backupBelowWarn, backupBelowError;
    logic lowPowerBackupOption, tempSensorReady, faultFlagLow, cautionFlagLow, presetPin;
    logic signed [15:0] junctionTemp;
    int error_cnt = 0;
    int checked = 0;
    always #5 core_clk = ~core_clk;
    efl_preset_driver pin (.core_clk(core_clk), .presetPin(presetPin));
    efl_fault_log #(.PRESET_MIN(20), .PRESET_MAX(40), .CLEAR_MIN(300)) dut (
        .core_clk(core_clk), .sys_rst(sys_rst), .clkEn(clkEn), .presetPin(presetPin),
        .clearFaultsCommand(clearFaultsCommand), .bissMode(bissMode), .regReq(regReq),
        .regWrite(regWrite), .regBank(regBank), .regAddr(regAddr), .regWData(regWData),
        .regRData(regRData), .regAck(regAck), .rawAngle(rawAngle), .rawTurns(rawTurns),
        .signalFault(flt[0]), .positionFault(flt[1]), .startupFault(flt[2]),
        .memoryFault(flt[3]), .magnetDetected(!flt[4]),
        .mainSupplyInRange(mainSupplyInRange), .backupPresent(backupPresent),
        .backupBelowWarn(backupBelowWarn), .backupBelowError(backupBelowError),
        .lowPowerBackupOption(lowPowerBackupOption), .tempSensorReady(tempSensorReady),
        .junctionTemp(junctionTemp), .singleTurnCount(singleTurnCount),
        .multiTurnCount(multiTurnCount), .faultFlagLow(faultFlagLow),
        .cautionFlagLow(cautionFlagLow));
    task automatic tk(input int n);
        repeat (n) @(negedge core_clk);
    endtask
    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // one register access; bank 0x44 unless told otherwise
    task automatic acc(input logic [7:0] a, input logic [7:0] e, input logic wr = 1'b0,
                       input logic [7:0] b = 8'h44, input logic ak = 1'b1,
                       input logic [7:0] m = 8'hff, input logic [7:0] d = 8'hff);
        regReq = 1'b1;
        regWrite = wr;
        regBank = b;
        regAddr = a;
        regWData = d;
        tk(1);
        regReq = 1'b0;
        chk("regAck", 16'(regAck), 16'(ak));
        if (ak) chk("regRData", 16'(regRData & m), 16'(e));
        tk(1);
    endtask
    task automatic clr();
        clearFaultsCommand = 1'b1;
        tk(1);
        clearFaultsCommand = 1'b0;
        tk(1);
    endtask
    task automatic t_regs();
        acc(8'h10, 8'h00);
        acc(8'h11, 8'h00);
        acc(8'h20, 8'h00);
        acc(8'h10, 8'h00, 1'b0, 8'h45);
        chk("flags", 16'({faultFlagLow, cautionFlagLow}), 16'h3);
        bissMode = 1'b0;
        acc(8'h10, 8'h00, 1'b0, 8'h44, 1'b0);
        bissMode = 1'b1;
        $display("test regs done");
    endtask
    task automatic t_faults();
        for (int i = 0; i < 5; i++) begin
            flt[i] = 1'b1;
            tk(1);
            flt[i] = 1'b0;
            tk(1);
            chk("faultFlagLow", 16'(faultFlagLow), 16'h0);
            acc(8'h10, (i < 4) ? 8'(1 << i) : 8'h20, 1'b1);
            acc(8'h10, (i < 4) ? 8'(1 << i) : 8'h20);
            clr();
            chk("faultFlagLow", 16'(faultFlagLow), 16'h1);
            acc(8'h10, 8'h00);
        end
        $display("test faults done");
    endtask
    task automatic t_caution();
        mainSupplyInRange = 1'b0;
        tk(1);
        mainSupplyInRange = 1'b1;
        tk(1);
        chk("cautionFlagLow", 16'(cautionFlagLow), 16'h0);
        acc(8'h11, 8'h01);
        clr();
        tempSensorReady = 1'b0;
        tk(2);
        acc(8'h11, 8'h02);
        acc(8'h12, efl_pkg::TEMP_HI_RST, 1'b1, 8'h44, 1'b1, 8'hff, 8'h64);
        tempSensorReady = 1'b1;
        tk(2);
        acc(8'h11, 8'h00);
        // the refused write above must have left the reset limit in place
        acc(8'h12, efl_pkg::TEMP_HI_RST, 1'b1, 8'h44, 1'b1, 8'hff, 8'h64);
        acc(8'h12, 8'h64);
        junctionTemp = 16'sd101;
        tk(2);
        acc(8'h11, 8'h04);
        junctionTemp = 16'sd25;
        acc(8'h12, 8'h64, 1'b1, 8'h44, 1'b1, 8'hff, efl_pkg::TEMP_HI_RST);
        clr();
        junctionTemp = 16'sd140;
        tk(2);
        acc(8'h11, 8'h00);
        junctionTemp = 16'sd141;
        tk(1);
        junctionTemp = 16'sd25;
        tk(1);
        acc(8'h11, 8'h04);
        junctionTemp = -16'sd40;
        tk(2);
        acc(8'h11, 8'h00, 1'b0, 8'h44, 1'b1, 8'h08);
        junctionTemp = -16'sd41;
        tk(2);
        acc(8'h11, 8'h08, 1'b0, 8'h44, 1'b1, 8'h08);
        junctionTemp = 16'sd25;
        tk(1);
        clr();
        acc(8'h11, 8'h00);
        $display("test caution done");
    endtask
    task automatic t_battery();
        backupBelowWarn = 1'b1;
        tk(2);
        acc(8'h11, 8'h10);
        backupBelowWarn = 1'b0;
        tk(2);
        acc(8'h11, 8'h00);
        backupPresent = 1'b0;
        tk(1);
        backupPresent = 1'b1;
        tk(6);
        acc(8'h10, 8'h10);
        pin.hold(301);
        tk(3);
        acc(8'h10, 8'h00);
        chk("faultFlagLow", 16'(faultFlagLow), 16'h1);
        backupBelowError = 1'b1;
        tk(2);
        acc(8'h10, 8'h10);
        backupBelowError = 1'b0;
        clr();
        $display("test battery done");
    endtask
    task automatic t_preset();
        rawAngle = 16'h1234;
        rawTurns = 16'h0056;
        tk(3);
        chk("singleTurnCount", singleTurnCount, 16'h1234);
        pin.hold(19);
        tk(4);
        chk("singleTurnCount", singleTurnCount, 16'h1234);
        pin.hold(41);
        tk(4);
        chk("multiTurnCount", multiTurnCount, 16'h0056);
        pin.hold(20);
        tk(4);
        chk("counts", singleTurnCount | multiTurnCount, 16'h0000);
        rawAngle = 16'h1239;
        tk(2);
        chk("singleTurnCount", singleTurnCount, 16'h0005);
        pin.hold(40);
        tk(4);
        chk("singleTurnCount", singleTurnCount, 16'h0000);
        // frozen: no count update, no fault capture, no acknowledge
        clkEn = 1'b0;
        rawAngle = 16'h1240;
        flt[0] = 1'b1;
        acc(8'h10, 8'h00, 1'b0, 8'h44, 1'b0);
        chk("singleTurnCount", singleTurnCount, 16'h0000);
        flt[0] = 1'b0;
        clkEn = 1'b1;
        tk(2);
        chk("singleTurnCount", singleTurnCount, 16'h0007);
        chk("faultFlagLow", 16'(faultFlagLow), 16'h1);
        $display("test preset done");
    endtask
    task automatic t_strap();
        flt[1] = 1'b1;
        tk(1);
        flt[1] = 1'b0;
        chk("faultFlagLow", 16'(faultFlagLow), 16'h0);
        // second reset with the backup option strap low
        sys_rst = 1'b1;
        lowPowerBackupOption = 1'b0;
        backupBelowError = 1'b1;
        backupBelowWarn = 1'b1;
        tk(2);
        sys_rst = 1'b0;
        tk(3);
        acc(8'h10, 8'h00);
        acc(8'h11, 8'h00);
        acc(8'h13, efl_pkg::TEMP_LO_RST);
        chk("flags", 16'({faultFlagLow, cautionFlagLow}), 16'h3);
        backupBelowError = 1'b0;
        backupBelowWarn = 1'b0;
        $display("test strap done");
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        core_clk = 0; sys_rst = 1; clearFaultsCommand = 0; bissMode = 1; regReq = 0;
        regWrite = 0; regBank = 0; regAddr = 0; regWData = 0; rawAngle = 0; rawTurns = 0;
        flt = 0; mainSupplyInRange = 1; backupPresent = 1; backupBelowWarn = 0;
        backupBelowError = 0; lowPowerBackupOption = 1; tempSensorReady = 1;
        junctionTemp = 16'sd25;
        clkEn = 1'b1;
        tk(8);
        sys_rst = 0;
        tk(2);
        t_regs();
        t_faults();
        t_caution();
        t_battery();
        t_preset();
        t_strap();
        end_sim();
    end
    // whole run is about 600 cycles; the 5000-cycle limit, some eight times that, is a hang
    initial begin
        #50us;
        error_cnt++;
        end_sim();
    end
endmodule // tb_top
bind efl_fault_log efl_checker chk_i (
    .core_clk(core_clk), .sys_rst(sys_rst), .clkEn(clkEn), .bissMode(bissMode),
    .regReq(regReq), .regBank(regBank), .regRData(regRData), .regAck(regAck),
    .signalFault(signalFault), .magnetDetected(magnetDetected),
    .mainSupplyInRange(mainSupplyInRange), .tempSensorReady(tempSensorReady),
    .junctionTemp(junctionTemp), .faultFlagLow(faultFlagLow),
    .cautionFlagLow(cautionFlagLow));
